//--- rtl/epcs_pkg.sv
package epcs_pkg;

   // core clock rate
   localparam int unsigned CLK_MHZ = 250;

   // lock indicators need this long of steady raw lock before rising
   localparam int unsigned LOCK_SETTLE_NS = 64;
   localparam int unsigned LOCK_SETTLE_CYC = (LOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;

   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_RATIO = 12'h008;
   localparam logic [11:0] ADDR_LOSS_CNT = 12'h00C;
   localparam logic [11:0] ADDR_PLL_INFO = 12'h010;

   // status field positions
   localparam int unsigned ST_TX_LOCK = 0;
   localparam int unsigned ST_CDR_LOCK = 1;
   localparam int unsigned ST_TX_LOST = 2;
   localparam int unsigned ST_CDR_LOST = 3;
   localparam int unsigned ST_ASYNC = 4;

   // loss counter field positions
   localparam int unsigned LC_TX_LSB = 0;
   localparam int unsigned LC_CDR_LSB = 8;

   // pll info field positions
   localparam int unsigned PI_OUT830 = 0;
   localparam int unsigned PI_REF_LSB = 4;

   // ratio field positions
   localparam int unsigned RA_REC_LSB = 0;
   localparam int unsigned RA_BY64_LSB = 8;
   localparam int unsigned RA_PLL_LSB = 16;

   // divide ratios
   localparam logic [7:0] RATIO_40GE = 8'h21;
   localparam logic [7:0] RATIO_BASE = 8'h42;
   localparam logic [7:0] RATIO_RS544 = 8'h44;
   localparam logic [7:0] RATIO_BY64 = 8'h40;
   localparam logic [7:0] RATIO_PLL_HALF = 8'h02;

   typedef enum logic [2:0] {
      ETH_10GE = 3'h0,
      ETH_25GE = 3'h1,
      ETH_40GE = 3'h2,
      ETH_50GE = 3'h3,
      ETH_100GE = 3'h4
   } epcs_eth_mode_t;

   typedef enum logic [2:0] {
      FEC_NONE = 3'h0,
      FEC_FIRECODE = 3'h1,
      FEC_RS528 = 3'h2,
      FEC_RS544 = 3'h3,
      FEC_RS272 = 3'h4
   } epcs_fec_mode_t;

   typedef enum logic [2:0] {
      PLL_MODE_805_FROM_156 = 3'h0,
      PLL_MODE_805_FROM_312 = 3'h1,
      PLL_MODE_805_FROM_322 = 3'h2,
      PLL_MODE_830_FROM_156 = 3'h3,
      PLL_MODE_830_FROM_312 = 3'h4
   } epcs_pll_mode_t;

   // reference clock codes reported in pll info
   localparam logic [1:0] REF_156 = 2'h0;
   localparam logic [1:0] REF_312 = 2'h1;
   localparam logic [1:0] REF_322 = 2'h2;

   // control register layout, lsb is eth mode
   typedef struct packed {
      logic rec64_en;
      logic rec_div_en;
      logic tx_div_en;
      logic pll_div_en;
      logic async_en;
      epcs_pll_mode_t pll_mode;
      epcs_fec_mode_t fec_mode;
      epcs_eth_mode_t eth_mode;
   } epcs_ctrl_t;

   localparam int unsigned CTRL_W = 14;
   localparam epcs_ctrl_t CTRL_RST = '{
      rec64_en: 1'b1, rec_div_en: 1'b1, tx_div_en: 1'b1, pll_div_en: 1'b1,
      async_en: 1'b0, pll_mode: PLL_MODE_805_FROM_156, fec_mode: FEC_NONE,
      eth_mode: ETH_25GE};

   // one divided clock: level plus one-cycle edge pulse
   typedef struct packed {
      logic clk;
      logic pulse;
   } epcs_divclk_t;

endpackage : epcs_pkg

//--- rtl/epcs_clk_div.sv
`timescale 1ns/1ps
module epcs_clk_div
   import epcs_pkg::*;
#(
   parameter int unsigned CNT_W = 8
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // control
   input wire logic i_enable,
   input wire logic i_tick,
   input wire logic [CNT_W-1:0] i_ratio,
   // divided clock
   output epcs_divclk_t o_div
);

   initial begin
      if (CNT_W < 2) begin
         $error("epcs_clk_div: CNT_W must be at least 2");
      end
   end

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic clk_q, clk_d;
   logic pulse_q, pulse_d;

   // count source ticks; a ratio change takes effect at the next tick, wrapping then if the count is already past it
   always_comb begin
      cnt_d = cnt_q;
      pulse_d = 1'b0;
      if (!i_enable) begin
         cnt_d = '0;
      end else if (i_tick) begin
         if (cnt_q >= i_ratio - 1'b1) begin
            cnt_d = '0;
            pulse_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
      // high in first half; odd ratios lean one tick low
      clk_d = i_enable && (cnt_d < (i_ratio >> 1));
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
         clk_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
         pulse_q <= pulse_d;
      end
   end

   assign o_div.clk = clk_q;
   assign o_div.pulse = pulse_q;

endmodule : epcs_clk_div

//--- rtl/epcs_lock_qual.sv
`timescale 1ns/1ps
module epcs_lock_qual
   import epcs_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = LOCK_SETTLE_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // raw lock from the loop
   input wire logic i_raw_lock,
   // qualified lock
   output logic o_locked,
   output logic o_lost
);

   initial begin
      if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin
         $error("epcs_lock_qual: SETTLE_CYC must be 1 to 255");
      end
   end

   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

   logic [7:0] cnt_q, cnt_d;
   logic lock_q, lock_d;
   logic lost_q, lost_d;

   // rise only after steady raw lock, fall at once so clients stop early
   always_comb begin
      cnt_d = cnt_q;
      lock_d = lock_q;
      lost_d = 1'b0;
      if (!i_raw_lock) begin
         cnt_d = '0;
         lock_d = 1'b0;
         lost_d = lock_q;
      end else if (!lock_q) begin
         if (cnt_q == SETTLE_LAST) begin
            lock_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
         lock_q <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lock_q <= lock_d;
         lost_q <= lost_d;
      end
   end

   assign o_locked = lock_q;
   assign o_lost = lost_q;

endmodule : epcs_lock_qual

//--- rtl/epcs_top.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module epcs_top
   import epcs_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = LOCK_SETTLE_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // source rate enables, one pulse per unit interval or pll cycle
   input wire logic i_rx_serial_tick,
   input wire logic i_tx_serial_tick,
   input wire logic i_sys_pll_tick,
   // raw lock from serializer pll and clock recovery
   input wire logic i_tx_pll_lock_raw,
   input wire logic i_cdr_lock_raw,
   // divided clocks
   output epcs_divclk_t o_rx_recovered_clock_by64,
   output epcs_divclk_t o_rec_div,
   output epcs_divclk_t o_tx_div,
   output epcs_divclk_t o_pll_half,
   // status and configuration
   output logic o_tx_pll_locked,
   output logic o_cdr_locked,
   output logic o_async_adapter_en,
   output epcs_pll_mode_t o_pll_mode
);

   // divide ratio for the recovered and tx divided clocks
   function automatic logic [7:0] line_ratio(input epcs_eth_mode_t eth,
                                             input epcs_fec_mode_t fec);
      logic [7:0] r;
      r = RATIO_BASE;
      if (fec == FEC_RS544 || fec == FEC_RS272) begin
         r = RATIO_RS544;
      end else if (eth == ETH_40GE && fec == FEC_NONE) begin
         r = RATIO_40GE;
      end
      return r;
   endfunction : line_ratio

   // reference clock implied by a pll mode
   function automatic logic [1:0] pll_ref(input epcs_pll_mode_t m);
      logic [1:0] r;
      r = REF_156;
      if (m == PLL_MODE_805_FROM_312 || m == PLL_MODE_830_FROM_312) begin
         r = REF_312;
      end else if (m == PLL_MODE_805_FROM_322) begin
         r = REF_322;
      end
      return r;
   endfunction : pll_ref

   // legal encodings only; others are refused by the bus
   function automatic logic ctrl_legal(input logic [31:0] w);
      logic ok;
      ok = (w[2:0] <= ETH_100GE) && (w[5:3] <= FEC_RS272) &&
           (w[8:6] <= PLL_MODE_830_FROM_312);
      return ok;
   endfunction : ctrl_legal

   epcs_ctrl_t ctrl_q, ctrl_d;
   logic tx_lost_q, tx_lost_d;
   logic cdr_lost_q, cdr_lost_d;
   logic [7:0] tx_loss_cnt_q, tx_loss_cnt_d;
   logic [7:0] cdr_loss_cnt_q, cdr_loss_cnt_d;
   logic [31:0] rdata_q, rdata_d;
   logic tx_locked;
   logic cdr_locked;
   logic tx_lost_ev;
   logic cdr_lost_ev;
   logic [7:0] ratio;
   logic setup;
   logic access;
   logic wr;
   logic mapped;
   logic wr_refused;
   logic [31:0] status_word;

   // apb phases; the slave never inserts wait states
   assign setup = i_psel && !i_penable;
   assign access = i_psel && i_penable;
   assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS) ||
                   (i_paddr == ADDR_RATIO) || (i_paddr == ADDR_LOSS_CNT) ||
                   (i_paddr == ADDR_PLL_INFO);
   assign wr_refused = i_pwrite && (i_paddr == ADDR_CTRL) && !ctrl_legal(i_pwdata);
   assign wr = access && i_pwrite && mapped && !wr_refused;
   assign o_pready = access;
   assign o_pslverr = access && (!mapped || wr_refused);

   assign ratio = line_ratio(ctrl_q.eth_mode, ctrl_q.fec_mode);

   // status word seen by software
   always_comb begin
      status_word = '0;
      status_word[ST_TX_LOCK] = tx_locked;
      status_word[ST_CDR_LOCK] = cdr_locked;
      status_word[ST_TX_LOST] = tx_lost_q;
      status_word[ST_CDR_LOST] = cdr_lost_q;
      status_word[ST_ASYNC] = ctrl_q.async_en;
   end

   // register next values; strobes honoured per byte lane, except that a loss counter write clears whatever the strobes
   always_comb begin
      ctrl_d = ctrl_q;
      tx_lost_d = tx_lost_q;
      cdr_lost_d = cdr_lost_q;
      tx_loss_cnt_d = tx_loss_cnt_q;
      cdr_loss_cnt_d = cdr_loss_cnt_q;
      if (wr && i_paddr == ADDR_CTRL) begin
         if (i_pstrb[0]) begin
            ctrl_d[7:0] = i_pwdata[7:0];
         end
         if (i_pstrb[1]) begin
            ctrl_d[CTRL_W-1:8] = i_pwdata[CTRL_W-1:8];
         end
      end
      // write one to clear; a loss in the same cycle keeps the flag set
      if (wr && i_paddr == ADDR_STATUS && i_pstrb[0]) begin
         if (i_pwdata[ST_TX_LOST]) begin
            tx_lost_d = 1'b0;
         end
         if (i_pwdata[ST_CDR_LOST]) begin
            cdr_lost_d = 1'b0;
         end
      end
      if (tx_lost_ev) begin
         tx_lost_d = 1'b1;
      end
      if (cdr_lost_ev) begin
         cdr_lost_d = 1'b1;
      end
      // any write clears the counters, then a fresh loss counts
      if (wr && i_paddr == ADDR_LOSS_CNT) begin
         tx_loss_cnt_d = '0;
         cdr_loss_cnt_d = '0;
      end
      // counters saturate rather than wrap, so a burst is never hidden
      if (tx_lost_ev && tx_loss_cnt_d != 8'hFF) begin
         tx_loss_cnt_d = tx_loss_cnt_d + 8'h01;
      end
      if (cdr_lost_ev && cdr_loss_cnt_d != 8'hFF) begin
         cdr_loss_cnt_d = cdr_loss_cnt_d + 8'h01;
      end
   end

   // read data latched in setup so it comes from a flip-flop in access
   always_comb begin
      rdata_d = rdata_q;
      if (setup) begin
         rdata_d = '0;
         unique case (i_paddr)
            ADDR_CTRL: begin
               rdata_d[CTRL_W-1:0] = ctrl_q;
            end
            ADDR_STATUS: begin
               rdata_d = status_word;
            end
            ADDR_RATIO: begin
               rdata_d[RA_REC_LSB +: 8] = ratio;
               rdata_d[RA_BY64_LSB +: 8] = RATIO_BY64;
               rdata_d[RA_PLL_LSB +: 8] = RATIO_PLL_HALF;
            end
            ADDR_LOSS_CNT: begin
               rdata_d[LC_TX_LSB +: 8] = tx_loss_cnt_q;
               rdata_d[LC_CDR_LSB +: 8] = cdr_loss_cnt_q;
            end
            ADDR_PLL_INFO: begin
               // output 830 MHz for the 830 modes, 805 MHz otherwise
               rdata_d[PI_OUT830] = (ctrl_q.pll_mode == PLL_MODE_830_FROM_156) ||
                                    (ctrl_q.pll_mode == PLL_MODE_830_FROM_312);
               rdata_d[PI_REF_LSB +: 2] = pll_ref(ctrl_q.pll_mode);
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q <= CTRL_RST;
         tx_lost_q <= 1'b0;
         cdr_lost_q <= 1'b0;
         tx_loss_cnt_q <= '0;
         cdr_loss_cnt_q <= '0;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         tx_lost_q <= tx_lost_d;
         cdr_lost_q <= cdr_lost_d;
         tx_loss_cnt_q <= tx_loss_cnt_d;
         cdr_loss_cnt_q <= cdr_loss_cnt_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_prdata = rdata_q;

   // serializer pll lock qualifier
   epcs_lock_qual #(
      .SETTLE_CYC(SETTLE_CYC)
   ) u_tx_lock (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_raw_lock(i_tx_pll_lock_raw),
      .o_locked(tx_locked),
      .o_lost(tx_lost_ev)
   );

   // clock recovery lock qualifier
   epcs_lock_qual #(
      .SETTLE_CYC(SETTLE_CYC)
   ) u_cdr_lock (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_raw_lock(i_cdr_lock_raw),
      .o_locked(cdr_locked),
      .o_lost(cdr_lost_ev)
   );

   assign o_tx_pll_locked = tx_locked;
   assign o_cdr_locked = cdr_locked;

   // recovered clock by 64 from the rx line rate
   epcs_clk_div #(
      .CNT_W(8)
   ) u_by64 (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_enable(ctrl_q.rec64_en),
      .i_tick(i_rx_serial_tick),
      .i_ratio(RATIO_BY64),
      .o_div(o_rx_recovered_clock_by64)
   );

   // recovered divided clock, ratio set by eth and fec mode
   epcs_clk_div #(
      .CNT_W(8)
   ) u_rec_div (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_enable(ctrl_q.rec_div_en),
      .i_tick(i_rx_serial_tick),
      .i_ratio(ratio),
      .o_div(o_rec_div)
   );

   // tx divided clock uses the same ratio on the tx line rate
   epcs_clk_div #(
      .CNT_W(8)
   ) u_tx_div (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_enable(ctrl_q.tx_div_en),
      .i_tick(i_tx_serial_tick),
      .i_ratio(ratio),
      .o_div(o_tx_div)
   );

   // system clock output at half the system pll rate
   epcs_clk_div #(
      .CNT_W(8)
   ) u_pll_half (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_enable(ctrl_q.pll_div_en),
      .i_tick(i_sys_pll_tick),
      .i_ratio(RATIO_PLL_HALF),
      .o_div(o_pll_half)
   );

   // client clocks need no relation to the system clock once this is set
   assign o_async_adapter_en = ctrl_q.async_en;
   // pll mode picks reference and output frequency outside the block
   assign o_pll_mode = ctrl_q.pll_mode;

endmodule : epcs_top

//--- verif/epcs_top_properties.sv
`timescale 1ns/1ps
module epcs_top_properties
   import epcs_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = LOCK_SETTLE_CYC
) (
   // clock, reset and bus
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [11:0] i_paddr,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // rate ticks and raw locks
   input wire logic i_rx_serial_tick,
   input wire logic i_sys_pll_tick,
   input wire logic i_tx_pll_lock_raw,
   input wire logic i_cdr_lock_raw,
   // watched outputs
   input wire epcs_divclk_t o_rec_div,
   input wire epcs_divclk_t o_rx_recovered_clock_by64,
   input wire epcs_divclk_t o_pll_half,
   input wire logic o_tx_pll_locked,
   input wire logic o_cdr_locked
);
   // one domain, so clock and disable are given once
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   // consecutive raw-high edges, saturating, so the settle bound follows the parameter
   logic [8:0] tx_run_q, tx_run_d, cdr_run_q, cdr_run_d;

   always_comb begin
      tx_run_d = tx_run_q;
      cdr_run_d = cdr_run_q;
      if (!i_tx_pll_lock_raw) begin
         tx_run_d = 9'h000;
      end else if (tx_run_q != 9'h1FF) begin
         tx_run_d = tx_run_q + 9'h001;
      end
      if (!i_cdr_lock_raw) begin
         cdr_run_d = 9'h000;
      end else if (cdr_run_q != 9'h1FF) begin
         cdr_run_d = cdr_run_q + 9'h001;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tx_run_q <= 9'h000;
         cdr_run_q <= 9'h000;
      end else begin
         tx_run_q <= tx_run_d;
         cdr_run_q <= cdr_run_d;
      end
   end

   ready_zero_wait_a: assert property (o_pready == (i_psel && i_penable))
      else $error("pready outside access cycle");
   err_in_access_a: assert property (o_pslverr |-> i_psel && i_penable)
      else $error("pslverr outside access cycle");
   unmapped_err_a: assert property (i_psel && i_penable && i_paddr > 12'h010 |-> o_pslverr)
      else $error("unmapped access without pslverr");
   rec_needs_tick_a: assert property (o_rec_div.pulse |-> $past(i_rx_serial_tick))
      else $error("recovered pulse without tick");
   rec_pulse_single_a: assert property (o_rec_div.pulse |=> !o_rec_div.pulse)
      else $error("recovered pulse longer than one cycle");
   by64_needs_tick_a: assert property (o_rx_recovered_clock_by64.pulse |-> $past(i_rx_serial_tick))
      else $error("by64 pulse without tick");
   half_needs_tick_a: assert property (o_pll_half.pulse |-> $past(i_sys_pll_tick))
      else $error("pll half pulse without tick");
   // lock must stand once raw lock has outlasted the settle time
   tx_lock_rise_a: assert property (tx_run_q > 9'(SETTLE_CYC) |-> o_tx_pll_locked)
      else $error("tx lock did not rise");
   cdr_lock_rise_a: assert property (cdr_run_q > 9'(SETTLE_CYC) |-> o_cdr_locked)
      else $error("cdr lock did not rise");
   tx_lock_drop_a: assert property (!i_tx_pll_lock_raw |=> !o_tx_pll_locked)
      else $error("tx lock held after loss");
   cdr_lock_drop_a: assert property (!i_cdr_lock_raw |=> !o_cdr_locked)
      else $error("cdr lock held after loss");

   // main scenarios reached
   cover property (o_rec_div.pulse);
   cover property ($rose(o_tx_pll_locked));
   cover property (o_pslverr);
endmodule : epcs_top_properties

bind epcs_top epcs_top_properties #(.SETTLE_CYC(SETTLE_CYC)) u_epcs_top_properties (
   .i_mclk, .i_rst, .i_psel, .i_penable, .i_paddr, .o_pready, .o_pslverr,
   .i_rx_serial_tick, .i_sys_pll_tick, .i_tx_pll_lock_raw, .i_cdr_lock_raw,
   .o_rec_div, .o_rx_recovered_clock_by64, .o_pll_half, .o_tx_pll_locked, .o_cdr_locked);

//--- verif/epcs_client_model.sv
`timescale 1ns/1ps
module epcs_client_model
   import epcs_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // clocks and status from the port
   input wire epcs_divclk_t i_tx_div,
   input wire epcs_divclk_t i_by64,
   input wire logic i_tx_locked,
   input wire logic i_cdr_locked,
   // edges the client took into use
   output int o_tx_used,
   output int o_rx_used
);
   // client runs on the core clock, standing in for the system-derived clock
   // edges before qualified lock are not trusted, so they are dropped
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_used <= 0;
         o_rx_used <= 0;
      end else begin
         if (i_tx_div.pulse && i_tx_locked) o_tx_used <= o_tx_used + 1;
         if (i_by64.pulse && i_cdr_locked) o_rx_used <= o_rx_used + 1;
      end
   end
endmodule : epcs_client_model

//--- verif/test_ethernet_port_clock_status.sv
`timescale 1ns/1ps
module test_ethernet_port_clock_status;
   import epcs_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [31:0] seed = 32'h561B0467;
   logic rx_tk = 1'b0, tx_tk = 1'b0, sys_tk = 1'b0, tx_raw = 1'b0, cdr_raw = 1'b0;
   logic tx_lk, cdr_lk, async_en;
   logic [13:0] m;
   epcs_divclk_t by64, rec, txd, pll;
   epcs_pll_mode_t pmode;
   int tx_used, rx_used, miscompares = 0, checks_done = 0;
   int n[4] = '{0, 0, 0, 0}, per[4], pc[4] = '{0, 0, 0, 0}, st[4];
   int h[4] = '{0, 0, 0, 0}, hp[4];
   logic [3:0] tk, pl, cl;
   assign cl = {pll.clk, txd.clk, by64.clk, rec.clk};
   assign tk = {sys_tk, tx_tk, rx_tk, rx_tk};
   assign pl = {pll.pulse, txd.pulse, by64.pulse, rec.pulse};

   epcs_top #(.SETTLE_CYC(2)) u_epcs_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_serial_tick(rx_tk),
      .i_tx_serial_tick(tx_tk), .i_sys_pll_tick(sys_tk), .i_tx_pll_lock_raw(tx_raw),
      .i_cdr_lock_raw(cdr_raw), .o_rx_recovered_clock_by64(by64), .o_rec_div(rec),
      .o_tx_div(txd), .o_pll_half(pll), .o_tx_pll_locked(tx_lk), .o_cdr_locked(cdr_lk),
      .o_async_adapter_en(async_en), .o_pll_mode(pmode));
   epcs_client_model u_epcs_client_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_tx_div(txd),
      .i_by64(by64), .i_tx_locked(tx_lk), .i_cdr_locked(cdr_lk), .o_tx_used(tx_used),
      .o_rx_used(rx_used));

   // 250 MHz core clock
   initial begin
      forever #2 i_mclk = ~i_mclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs

   // expected line ratio from eth and fec fields
   function automatic int ratio_of(input logic [13:0] c);
      if (c[5:3] >= 3) return 68;
      if (c[2:0] == 3'h2 && c[5:3] == 3'h0) return 33;
      return 66;
   endfunction : ratio_of

   function automatic logic [31:0] info_of(input logic [2:0] p);
      logic [1:0] r;
      r = (p == 3'h2) ? 2'h2 : ((p == 3'h1 || p == 3'h4) ? 2'h1 : 2'h0);
      return {26'h0, r, 3'h0, p >= 3'h3};
   endfunction : info_of

   // irregular ticks so periods are counted in ticks, not cycles
   always @(posedge i_mclk) begin
      seed <= xs(seed);
      rx_tk <= seed[0] | seed[1];
      tx_tk <= seed[2] | seed[3];
      sys_tk <= seed[4] | seed[5];
   end

   // ticks between successive pulses of each divider
   always @(posedge i_mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (pl[i] === 1'b1) begin
            per[i] = n[i];
            hp[i] = h[i];
            n[i] = int'(tk[i]);
            h[i] = int'(tk[i] & cl[i]);
            pc[i]++;
         end else begin
            n[i] = n[i] + int'(tk[i]);
            h[i] = h[i] + int'(tk[i] & cl[i]);
         end
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      pen <= 1'b1;
      @(posedge i_mclk);
      while (pready !== 1'b1) @(posedge i_mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // cuts a hang well beyond the expected run
   initial begin
      repeat (60000) @(posedge i_mclk);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h3C01);
      apb(1'b0, ADDR_RATIO, 32'h0);
      chk(rd, 32'h00024042);
      chk({pmode, async_en, tx_lk, cdr_lk}, 32'h0);
      // every eth and fec pair, pll modes rotating
      for (int e = 0; e < 5; e++) begin
         for (int f = 0; f < 5; f++) begin
            m = {4'hF, seed[9], 3'((e + f) % 5), 3'(f), 3'(e)};
            apb(1'b1, ADDR_CTRL, {18'h0, m});
            chk(err, 1'b0);
            apb(1'b0, ADDR_RATIO, 32'h0);
            chk(rd, {8'h0, 8'h02, 8'h40, 8'(ratio_of(m))});
            apb(1'b0, ADDR_PLL_INFO, 32'h0);
            chk(rd, info_of(m[8:6]));
            chk({async_en, pmode}, m[9:6]);
            for (int i = 0; i < 4; i++) st[i] = pc[i];
            for (int i = 0; i < 4; i++) wait (pc[i] >= st[i] + 3);
            @(posedge i_mclk);
            chk(per[0], ratio_of(m));
            chk(per[1], 64);
            chk(per[2], ratio_of(m));
            chk(per[3], 2);
            // clock level high for half the ticks, odd ratios rounded down
            chk(hp[0], ratio_of(m) / 2);
            chk(hp[1], 32);
            chk(hp[2], ratio_of(m) / 2);
            chk(hp[3], 1);
         end
      end
      // refused and ignored accesses leave state alone
      apb(1'b1, ADDR_CTRL, 32'h0005);
      chk(err, 1'b1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, {18'h0, m});
      apb(1'b1, ADDR_RATIO, 32'h0);
      chk(err, 1'b0);
      apb(1'b0, 12'h020, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      // lock, loss, sticky flags and counters
      chk(tx_used + rx_used, 0);
      tx_raw <= 1'b1;
      cdr_raw <= 1'b1;
      repeat (200) @(posedge i_mclk);
      chk({tx_lk, cdr_lk}, 2'b11);
      chk(tx_used > 0 && rx_used > 0, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, {27'h0, m[9], 4'h3});
      tx_raw <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk({tx_lk, cdr_lk}, 2'b01);
      cdr_raw <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk(cdr_lk, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, {27'h0, m[9], 4'hC});
      apb(1'b0, ADDR_LOSS_CNT, 32'h0);
      chk(rd, 32'h0101);
      apb(1'b1, ADDR_STATUS, 32'h0C);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, {27'h0, m[9], 4'h0});
      apb(1'b1, ADDR_LOSS_CNT, 32'h0);
      apb(1'b0, ADDR_LOSS_CNT, 32'h0);
      chk(rd, 32'h0);
      // clearing the enables parks every divider low with no pulses
      apb(1'b1, ADDR_CTRL, {18'h0, 4'h0, m[9:0]});
      repeat (4) @(posedge i_mclk);
      for (int i = 0; i < 4; i++) st[i] = pc[i];
      repeat (200) @(posedge i_mclk);
      for (int i = 0; i < 4; i++) chk(pc[i], st[i]);
      chk({by64.clk, rec.clk, txd.clk, pll.clk}, 4'h0);
      tally_and_finish();
   end
endmodule : test_ethernet_port_clock_status
